// >>> rtl/lbd_pkg.sv
package lbd_pkg;
  // =====================================================
  // timing
  localparam int unsigned LBD_CLK_MHZ = 125;
  localparam int unsigned LBD_RESP_NS = 50;
  localparam int unsigned LBD_RESP_CYC = (LBD_RESP_NS * LBD_CLK_MHZ) / 1000;
  localparam int unsigned LBD_REFRESH_MS = 10;
  localparam int unsigned LBD_REFRESH_CYC = LBD_REFRESH_MS * 1000 * LBD_CLK_MHZ;
  // =====================================================
  // lookup table location
  localparam logic [7:0] LBD_LUT_DEV = 8'hA6;
  localparam logic [7:0] LBD_LUT_LAST = 8'h7F;
  localparam int unsigned LBD_IDX_W = 7;
  localparam int unsigned LBD_FRAC_W = 15;
  // =====================================================
  // register offsets
  localparam logic [7:0] LBD_OFS_CTRL = 8'h00;
  localparam logic [7:0] LBD_OFS_BIAS = 8'h01;
  localparam logic [7:0] LBD_OFS_SETPT = 8'h02;
  localparam logic [7:0] LBD_OFS_GAIN = 8'h03;
  localparam logic [7:0] LBD_OFS_HOLD = 8'h04;
  localparam logic [7:0] LBD_OFS_STATUS = 8'h05;
  // =====================================================
  // control fields
  localparam int unsigned LBD_B_LUT = 0;
  localparam int unsigned LBD_B_FS = 1;
  localparam int unsigned LBD_B_APC = 2;
  localparam int unsigned LBD_B_RAMP = 3;
  localparam int unsigned LBD_B_AFTER = 4;
  localparam int unsigned LBD_AFT_FS_SLP = 0;
  localparam int unsigned LBD_AFT_LUT_SLP = 1;
  localparam int unsigned LBD_AFT_FS_DIS = 2;
  localparam int unsigned LBD_AFT_LUT_DIS = 3;
  // =====================================================
  // reset values
  localparam logic [2:0] LBD_MODE_RST = 3'h0;
  localparam logic LBD_RAMP_RST = 1'b1;
  localparam logic [7:0] LBD_SETPT_RST = 8'h80;
  localparam logic [3:0] LBD_GAIN_RST = 4'h8;
  localparam logic [15:0] LBD_HOLD_RST = 16'h0010;
  // =====================================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } lbd_bus_req_t;
  typedef struct packed {
    logic req;
    logic [7:0] dev;
    logic [7:0] addr;
  } lbd_ee_req_t;
  typedef struct packed {
    logic ack;
    logic [7:0] data;
  } lbd_ee_rsp_t;
  typedef enum logic [2:0] {
    LBD_ST_CFG = 3'b000,
    LBD_ST_IDLE = 3'b001,
    LBD_ST_LUT = 3'b010,
    LBD_ST_FS = 3'b011
  } lbd_state_t;
endpackage : lbd_pkg

// >>> rtl/lbd_top.sv
// Function
// - gaps pass comparator straight to output
// - in burst, raise output on first light
// - in burst, ignore brief comparator dips
// - respond within 50ns of burst start
// - raise output on late light in burst
// - drop only after low beyond hold time
// - raise again when light returns
// - release latch at burst end or hold
// - output held high during fast start
// - mode 000: code changes only by host or by a search already in flight
// - mode 001: code refreshed from table
// - mode 100: loop from near-zero start
// - mode 101: table preload then loop
// - mode 111: preload, search, then loop
// - mode bits: preload, search, loop on
// - loop bit clear open, set closed
// - open loop table reload every 10ms
// - table at A6h, index upper 7 bits
// - ramp on: step code one per cycle
// - ramp off: apply code at once
// - error shifted left by gain into wide accumulator
// - one-shot bits cleared after action
// - mode loaded from eeprom at power-up
// - sleep and disable copy after-settings
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lbd_top #(
  parameter int unsigned BIAS_W = 10,
  parameter int unsigned TEMP_W = 8,
  parameter int unsigned REFRESH_CYC = lbd_pkg::LBD_REFRESH_CYC,
  parameter logic [7:0] CFG_DEV = 8'hA0,
  parameter logic [7:0] CFG_ADDR = 8'h00
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire lbd_pkg::lbd_bus_req_t bus_i,
  output logic [15:0] rdata_o,
  input wire logic cmp_raw_i,
  input wire logic burst_window_in_i,
  input wire logic sleep_i,
  input wire logic tx_disable_i,
  input wire logic [TEMP_W-1:0] temp_raw_i,
  input wire logic [7:0] mpd_power_i,
  input wire logic mpd_valid_i,
  output lbd_pkg::lbd_ee_req_t ee_req_o,
  input wire lbd_pkg::lbd_ee_rsp_t ee_rsp_i,
  output logic fs_start_o,
  input wire logic fs_done_i,
  input wire logic [BIAS_W-1:0] fs_code_i,
  output logic light_detect_out_o,
  output logic [BIAS_W-1:0] bias_code_o
);
  import lbd_pkg::*;

  localparam int ACC_W = BIAS_W + LBD_FRAC_W;
  localparam int REF_W = $clog2(REFRESH_CYC + 1);
  localparam int LD_RESP_MAX = LBD_RESP_CYC - 2;

  // sync lanes: 0 comparator, 1 burst window, 2 sleep, 3 laser disable
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    lbd_state_t st;
    logic [2:0] mode;
    logic ramp;
    logic [3:0] after;
    logic [7:0] setpt;
    logic [3:0] gain;
    logic [15:0] hold;
    logic [15:0] lowcnt;
    logic ld;
    logic [BIAS_W-1:0] target;
    logic [BIAS_W-1:0] code;
    logic [ACC_W-1:0] acc;
    logic [REF_W-1:0] tmr;
    logic due;
    logic cfg_done;
    logic fs_busy;
    lbd_ee_req_t ee;
    logic [15:0] rdata;
  } lbd_regs_t;

  localparam lbd_regs_t RST_VAL = '{
    st: LBD_ST_CFG,
    mode: LBD_MODE_RST,
    ramp: LBD_RAMP_RST,
    setpt: LBD_SETPT_RST,
    gain: LBD_GAIN_RST,
    hold: LBD_HOLD_RST,
    ee: '{req: 1'b0, dev: 8'h00, addr: 8'h00},
    default: '0
  };

  lbd_regs_t q;
  lbd_regs_t d;

  logic cmp;
  logic burst_window_in;
  logic opp;
  logic sleep_rise;
  logic dis_rise;
  logic wr_ctrl;
  logic signed [8:0] err;
  logic signed [ACC_W+1:0] delta;
  logic signed [ACC_W+1:0] sum;

  assign cmp = q.s2[0];
  assign burst_window_in = q.s2[1];
  // preload and search wait for the laser to be enabled and awake
  assign opp = !q.s2[2] && !q.s2[3];
  assign sleep_rise = q.s2[2] && !q.s3[2];
  assign dis_rise = q.s2[3] && !q.s3[3];
  assign wr_ctrl = bus_i.we && (bus_i.addr == LBD_OFS_CTRL);

  // =====================================================
  // next state
  always_comb begin
    d = q;
    d.s1 = {tx_disable_i, sleep_i, burst_window_in_i, cmp_raw_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    err = $signed({1'b0, q.setpt}) - $signed({1'b0, mpd_power_i});
    delta = $signed({{(ACC_W - 7){err[8]}}, err}) <<< q.gain;
    sum = $signed({2'b00, q.acc}) + delta;

    // light detect
    if (q.fs_busy) begin
      d.ld = 1'b1;
      d.lowcnt = '0;
    end else if (!burst_window_in) begin
      d.ld = cmp;
      d.lowcnt = '0;
    end else if (cmp) begin
      d.ld = 1'b1;
      d.lowcnt = '0;
    end else if (q.ld) begin
      if (q.lowcnt == q.hold) begin
        d.ld = 1'b0;
        d.lowcnt = '0;
      end else begin
        d.lowcnt = q.lowcnt + 16'h0001;
      end
    end

    // refresh timer for open loop table mode
    if (q.tmr == '0) begin
      d.tmr = REF_W'(REFRESH_CYC - 1);
      d.due = 1'b1;
    end else begin
      d.tmr = q.tmr - REF_W'(1);
    end

    // bias sequencer
    unique case (q.st)
      LBD_ST_CFG: begin
        d.ee = '{req: 1'b1, dev: CFG_DEV, addr: CFG_ADDR};
        if (q.ee.req && ee_rsp_i.ack) begin
          d.mode = ee_rsp_i.data[2:0];
          d.ee.req = 1'b0;
          d.cfg_done = 1'b1;
          d.st = LBD_ST_IDLE;
        end
      end
      LBD_ST_IDLE: begin
        if (q.mode[LBD_B_APC] && mpd_valid_i) begin
          if (sum[ACC_W+1]) begin
            d.acc = '0;
          end else if (sum[ACC_W]) begin
            d.acc = '1;
          end else begin
            d.acc = sum[ACC_W-1:0];
          end
          d.target = d.acc[ACC_W-1 -: BIAS_W];
        end
        if (q.mode[LBD_B_LUT] && (q.mode[LBD_B_APC] ? opp : q.due)) begin
          d.st = LBD_ST_LUT;
          d.due = 1'b0;
          d.ee = '{req: 1'b1, dev: LBD_LUT_DEV, addr: {1'b0, temp_raw_i[TEMP_W-1 -: LBD_IDX_W]}};
        end else if (q.mode[LBD_B_APC] && q.mode[LBD_B_FS] && opp) begin
          d.st = LBD_ST_FS;
          d.fs_busy = 1'b1;
        end
      end
      LBD_ST_LUT: begin
        if (ee_rsp_i.ack) begin
          d.ee.req = 1'b0;
          // a fetch that the host cancelled in flight still has to finish on the wire,
          // but its data must not overwrite a code the host has taken over since
          if (q.mode[LBD_B_LUT]) begin
            d.target = BIAS_W'(ee_rsp_i.data);
            d.acc = {BIAS_W'(ee_rsp_i.data), {LBD_FRAC_W{1'b0}}};
          end
          if (q.mode[LBD_B_APC]) begin
            d.mode[LBD_B_LUT] = 1'b0;
          end
          if (q.mode[LBD_B_APC] && q.mode[LBD_B_FS]) begin
            d.st = LBD_ST_FS;
            d.fs_busy = 1'b1;
          end else begin
            d.st = LBD_ST_IDLE;
          end
        end
      end
      LBD_ST_FS: begin
        if (fs_done_i) begin
          d.fs_busy = 1'b0;
          d.target = fs_code_i;
          d.acc = {fs_code_i, {LBD_FRAC_W{1'b0}}};
          d.mode[LBD_B_FS] = 1'b0;
          d.st = LBD_ST_IDLE;
        end
      end
      default: begin
        d.st = LBD_ST_IDLE;
        d.fs_busy = 1'b0;
        d.ee.req = 1'b0;
      end
    endcase

    // host access; a host set lands after the hardware clear and wins
    d.rdata = '0;
    if (bus_i.we) begin
      unique case (bus_i.addr)
        LBD_OFS_CTRL: begin
          d.mode = bus_i.wdata[LBD_B_APC:LBD_B_LUT];
          d.ramp = bus_i.wdata[LBD_B_RAMP];
          d.after = bus_i.wdata[LBD_B_AFTER +: 4];
        end
        LBD_OFS_BIAS: begin
          d.target = bus_i.wdata[BIAS_W-1:0];
          d.acc = {bus_i.wdata[BIAS_W-1:0], {LBD_FRAC_W{1'b0}}};
        end
        LBD_OFS_SETPT: d.setpt = bus_i.wdata[7:0];
        LBD_OFS_GAIN: d.gain = bus_i.wdata[3:0];
        LBD_OFS_HOLD: d.hold = bus_i.wdata;
        default: begin
        end
      endcase
    end
    if (bus_i.re) begin
      unique case (bus_i.addr)
        LBD_OFS_CTRL: d.rdata = {8'h00, q.after, q.ramp, q.mode};
        LBD_OFS_BIAS: d.rdata = 16'(q.code);
        LBD_OFS_SETPT: d.rdata = {8'h00, q.setpt};
        LBD_OFS_GAIN: d.rdata = {12'h000, q.gain};
        LBD_OFS_HOLD: d.rdata = q.hold;
        LBD_OFS_STATUS: d.rdata = {10'h000, q.st, q.cfg_done, q.fs_busy, q.ld};
        default: d.rdata = '0;
      endcase
    end

    // after-settings retrigger the one-shots
    if (sleep_rise) begin
      d.mode[LBD_B_FS] = q.after[LBD_AFT_FS_SLP];
      d.mode[LBD_B_LUT] = q.after[LBD_AFT_LUT_SLP];
    end
    if (dis_rise) begin
      d.mode[LBD_B_FS] = q.after[LBD_AFT_FS_DIS];
      d.mode[LBD_B_LUT] = q.after[LBD_AFT_LUT_DIS];
    end

    // ramping keeps the dac free of large glitches at the cost of slew time
    if (!q.ramp) begin
      d.code = q.target;
    end else if (q.code < q.target) begin
      d.code = q.code + BIAS_W'(1);
    end else if (q.code > q.target) begin
      d.code = q.code - BIAS_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      q <= RST_VAL;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign ee_req_o = q.ee;
  assign fs_start_o = q.fs_busy;
  assign light_detect_out_o = q.ld;
  assign bias_code_o = q.code;

  // =====================================================
  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i || !clk_en_i);

  a_gap_transparent: assert property (!burst_window_in && !q.fs_busy |=> q.ld == $past(cmp))
    else $error("gap output not transparent");
  a_burst_rise: assert property (burst_window_in && cmp |=> q.ld)
    else $error("output not raised on light");
  a_dip_ignored: assert property (burst_window_in && !cmp && q.ld && (q.lowcnt != q.hold) |=> q.ld)
    else $error("output followed a short dip");
  a_burst_resp: assert property ($rose(burst_window_in) && cmp |-> ##[1:LD_RESP_MAX] q.ld)
    else $error("late response after burst start");
  a_hold_drop: assert property (burst_window_in && !cmp && !q.fs_busy && q.ld && (q.lowcnt == q.hold) |=> !q.ld)
    else $error("output not dropped after hold");
  a_fs_high: assert property (q.fs_busy |=> q.ld)
    else $error("output low during fast start");
  a_static_code: assert property ((q.mode == 3'h0) && (q.st == LBD_ST_IDLE) && !bus_i.we |=> $stable(q.target))
    else $error("static mode target moved");
  a_ramp_step: assert property (q.ramp && (q.code != q.target) |=>
      (q.code == $past(q.code) + BIAS_W'(1)) || (q.code == $past(q.code) - BIAS_W'(1)))
    else $error("ramp step not one");
  a_no_ramp: assert property (!q.ramp |=> q.code == $past(q.target))
    else $error("code not applied at once");
  a_lut_addr: assert property (q.ee.req && (q.st == LBD_ST_LUT) |->
      (q.ee.dev == LBD_LUT_DEV) && (q.ee.addr <= LBD_LUT_LAST))
    else $error("bad table address");
  a_fs_clear: assert property ((q.st == LBD_ST_FS) && fs_done_i && !bus_i.we && !sleep_rise && !dis_rise
      |=> !q.mode[LBD_B_FS] && (q.target == $past(fs_code_i)))
    else $error("search bit not cleared");
  a_sleep_copy: assert property (sleep_rise && !dis_rise |=> q.mode[LBD_B_FS] == $past(q.after[LBD_AFT_FS_SLP]))
    else $error("sleep copy missing");

  // one-shot bookkeeping: the host write and the pin copies win over the hardware clear,
  // so every clear check steps aside in the cycles where either of them lands
  a_lut_clear: assert property ((q.st == LBD_ST_LUT) && ee_rsp_i.ack && q.mode[LBD_B_APC]
      && !wr_ctrl && !sleep_rise && !dis_rise |=> !q.mode[LBD_B_LUT])
    else $error("preload bit not cleared");
  a_dis_copy: assert property (dis_rise |=> (q.mode[LBD_B_LUT] == $past(q.after[LBD_AFT_LUT_DIS]))
      && (q.mode[LBD_B_FS] == $past(q.after[LBD_AFT_FS_DIS])))
    else $error("disable copy missing");
  a_cfg_load: assert property ((q.st == LBD_ST_CFG) && q.ee.req && ee_rsp_i.ack && !wr_ctrl
      && !sleep_rise && !dis_rise |=> (q.mode == $past(ee_rsp_i.data[2:0])) && (q.st == LBD_ST_IDLE))
    else $error("mode not loaded from config");

  // sequencer entry and exit
  a_fs_enter: assert property ((q.st == LBD_ST_IDLE) && (q.mode == 3'b110) && opp |=> q.fs_busy)
    else $error("search not started");
  a_fs_state: assert property (q.fs_busy |-> (q.st == LBD_ST_FS))
    else $error("search busy outside search");
  a_lut_due: assert property ((q.st == LBD_ST_IDLE) && q.mode[LBD_B_LUT] && !q.mode[LBD_B_APC] && q.due
      |=> (q.st == LBD_ST_LUT) && q.ee.req)
    else $error("table refresh not started");
  a_ee_hold: assert property (q.ee.req && !ee_rsp_i.ack |=> q.ee.req && $stable(q.ee.dev) && $stable(q.ee.addr))
    else $error("table request moved before ack");

  // code path
  a_loop_off: assert property ((q.st == LBD_ST_IDLE) && !q.mode[LBD_B_APC] && !bus_i.we |=> $stable(q.acc))
    else $error("open loop accumulator moved");
  a_ramp_rest: assert property (q.ramp && (q.code == q.target) |=> $stable(q.code))
    else $error("ramp moved a settled code");
  a_ld_count: assert property (burst_window_in && !cmp && q.ld && !q.fs_busy && (q.lowcnt != q.hold)
      |=> q.lowcnt == $past(q.lowcnt) + 16'h0001)
    else $error("dip counter did not count");

  c_ld_drop: cover property (burst_window_in && q.ld ##1 !q.ld && burst_window_in);
  c_fs_done: cover property ((q.st == LBD_ST_FS) && fs_done_i);
  c_lut_refresh: cover property ((q.st == LBD_ST_LUT) && !q.mode[LBD_B_APC] && ee_rsp_i.ack);
  c_sleep_retrig: cover property (sleep_rise && q.after[LBD_AFT_FS_SLP]);
  c_burst_resp: cover property ($rose(burst_window_in) && cmp ##1 q.ld);
endmodule : lbd_top
`default_nettype wire

// >>> verif/lbd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module lbd_far_model
  import lbd_pkg::*;
#(
  parameter int unsigned EE_DLY = 3,
  parameter int unsigned FS_DLY = 9,
  parameter logic [9:0] FS_CODE = 10'h2a5
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire lbd_pkg::lbd_ee_req_t ee_req_i,
  output lbd_pkg::lbd_ee_rsp_t ee_rsp_o,
  input wire logic fs_start_i,
  output logic fs_done_o,
  output logic [9:0] fs_code_o
);
  // =====================================================
  // eeprom and search engine
  logic ack_q;
  logic [7:0] ecnt_q;
  logic [7:0] fcnt_q;
  logic [7:0] val;
  // content is addr + 21h, so the config byte at 00h gives mode 001
  assign val = ee_req_i.addr + 8'h21;
  // data is scrambled outside the ack cycle, never a stale copy
  assign ee_rsp_o = '{ack_q, ack_q ? val : ~val};
  assign fs_code_o = fs_done_o ? FS_CODE : ~FS_CODE;
  always @(posedge clk_i) begin
    ack_q <= 1'b0;
    fs_done_o <= 1'b0;
    if (srst_i) begin
      ecnt_q <= 8'h00;
      fcnt_q <= 8'h00;
    end else begin
      if (ee_req_i.req && !ack_q) begin
        ecnt_q <= (ecnt_q == EE_DLY[7:0]) ? 8'h00 : ecnt_q + 8'h01;
        ack_q <= (ecnt_q == EE_DLY[7:0]);
      end
      if (fs_start_i && !fs_done_o) begin
        fcnt_q <= (fcnt_q == FS_DLY[7:0]) ? 8'h00 : fcnt_q + 8'h01;
        fs_done_o <= (fcnt_q == FS_DLY[7:0]);
      end
    end
  end
endmodule : lbd_far_model
`default_nettype wire

// >>> verif/lbd_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module lbd_top_test;
  import lbd_pkg::*;
  logic ref_clk_i = 1'b0, srst_i = 1'b1, cmp = 1'b0, win = 1'b0, slp = 1'b0, dis = 1'b0, mv = 1'b0, en = 1'b1;
  lbd_bus_req_t bus_i = '0;
  logic [15:0] rdata_o;
  logic [7:0] temp = 8'h2c, pw = 8'h80;
  lbd_ee_req_t ee_req_o;
  lbd_ee_rsp_t ee_rsp;
  logic fs_start_o, fs_done, light_o;
  logic [9:0] fs_code, code;
  int bad_count = 0, checked = 0, i;
  always #4 ref_clk_i = ~ref_clk_i;
  lbd_top #(.REFRESH_CYC(16)) lbd_top_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(en), .bus_i(bus_i),
    .rdata_o(rdata_o), .cmp_raw_i(cmp), .burst_window_in_i(win), .sleep_i(slp), .tx_disable_i(dis),
    .temp_raw_i(temp), .mpd_power_i(pw), .mpd_valid_i(mv), .ee_req_o(ee_req_o), .ee_rsp_i(ee_rsp),
    .fs_start_o(fs_start_o), .fs_done_i(fs_done), .fs_code_i(fs_code), .light_detect_out_o(light_o),
    .bias_code_o(code));
  lbd_far_model lbd_far_model_i (.clk_i(ref_clk_i), .srst_i(srst_i), .ee_req_i(ee_req_o), .ee_rsp_o(ee_rsp),
    .fs_start_i(fs_start_o), .fs_done_o(fs_done), .fs_code_o(fs_code));
  // =====================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i);
    bus_i.we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    bus_i <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    bus_i.re <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // =====================================================
  // scenarios
  task automatic t_light;
    wr(LBD_OFS_HOLD, 16'h0004);
    cmp <= 1'b0;
    cyc(4);
    win <= 1'b1;
    cmp <= 1'b1;
    cyc(3);
    chk(light_o, 1'b1, "burst rise");
    for (i = 0; i < 6; i++) begin
      if (i == 2) cmp <= 1'b1;
      else if (i == 0) cmp <= 1'b0;
      cyc(1);
      chk(light_o, 1'b1, "dip");
    end
    cmp <= 1'b0;
    cyc(6);
    chk(light_o, 1'b1, "hold");
    cyc(6);
    chk(light_o, 1'b0, "drop");
    cmp <= 1'b1;
    cyc(3);
    chk(light_o, 1'b1, "return");
    win <= 1'b0;
    cmp <= 1'b0;
    cyc(3);
    chk(light_o, 1'b0, "gap low");
    cmp <= 1'b1;
    cyc(3);
    chk(light_o, 1'b1, "gap high");
    en <= 1'b0;
    cmp <= 1'b0;
    cyc(5);
    chk(light_o, 1'b1, "frozen");
    en <= 1'b1;
    cyc(4);
    chk(light_o, 1'b0, "thawed");
    cmp <= 1'b0;
    $display("light test done");
  endtask : t_light
  task automatic t_open;
    logic [15:0] d;
    rd(LBD_OFS_CTRL, d);
    chk(d[2:0], 3'b001, "cfg mode");
    wr(LBD_OFS_CTRL, 16'h0001);
    for (i = 0; i < 40 && ee_req_o.req !== 1'b1; i++) cyc(1);
    chk({ee_req_o.dev, ee_req_o.addr}, 16'ha616, "table addr");
    cyc(40);
    chk(code, 10'h037, "table code");
    wr(LBD_OFS_CTRL, 16'h0000);
    wr(LBD_OFS_BIAS, 16'h0123);
    cyc(2);
    chk(code, 10'h123, "direct");
    temp <= 8'h80;
    cyc(40);
    chk(code, 10'h123, "static");
    wr(LBD_OFS_CTRL, 16'h0008);
    wr(LBD_OFS_BIAS, 16'h0128);
    for (i = 0; i < 6 && code === 10'h123; i++) cyc(1);
    chk(code, 10'h124, "ramp first");
    for (i = 5; i < 9; i++) begin
      cyc(1);
      chk(code, 16'h0120 + i, "ramp step");
    end
    $display("open loop test done");
  endtask : t_open
  task automatic t_closed;
    logic [15:0] d;
    wr(LBD_OFS_CTRL, 16'h0007);
    for (i = 0; i < 60 && fs_start_o !== 1'b1; i++) cyc(1);
    chk(fs_start_o, 1'b1, "search start");
    cyc(2);
    chk(light_o, 1'b1, "search light");
    for (i = 0; i < 30 && fs_start_o === 1'b1; i++) cyc(1);
    cyc(2);
    chk(code, 10'h2a5, "search code");
    rd(LBD_OFS_CTRL, d);
    chk(d[2:0], 3'b100, "one-shot clear");
    pw <= 8'h00;
    mv <= 1'b1;
    cyc(8);
    mv <= 1'b0;
    cyc(3);
    chk(code > 10'h2a5, 1'b1, "loop rises");
    pw <= 8'h80;
    $display("closed loop test done");
  endtask : t_closed
  task automatic t_sleep;
    wr(LBD_OFS_CTRL, 16'h0014);
    slp <= 1'b1;
    cyc(6);
    slp <= 1'b0;
    for (i = 0; i < 40 && fs_start_o !== 1'b1; i++) cyc(1);
    chk(fs_start_o, 1'b1, "sleep search");
    cyc(30);
    wr(LBD_OFS_CTRL, 16'h0084);
    dis <= 1'b1;
    cyc(6);
    dis <= 1'b0;
    for (i = 0; i < 40 && ee_req_o.req !== 1'b1; i++) cyc(1);
    chk(ee_req_o.dev, 8'ha6, "disable preload");
    cyc(20);
    $display("sleep test done");
  endtask : t_sleep
  initial begin
    cyc(12);
    srst_i <= 1'b0;
    cyc(30);
    t_light();
    t_open();
    t_closed();
    t_sleep();
    end_sim();
  end
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
endmodule : lbd_top_test
`default_nettype wire
